// *** rtl/sws_frontend.sv ***
`timescale 1ns/10ps
`default_nettype none
module sws_frontend import sws_pkg::*; #(
  parameter int RST_MIN_CYC = SWS_RST_MIN_CYC,
  parameter int RST_MAX_CYC = SWS_RST_MAX_CYC,
  parameter int PRES_CYC = SWS_PRES_CYC,
  parameter int MEM_SIZE = 65536,
  parameter logic [7:0] FAMILY_CODE = 8'h5a,      // Arbitrary value
  parameter logic [31:0] LOT_WAFER_ID = 32'h01234567, // Arbitrary value
  parameter logic [7:0] DIE_X = 8'h11,            // Arbitrary value
  parameter logic [7:0] DIE_Y = 8'h22             // Arbitrary value
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Shared open-drain data line
  input wire logic line_in,
  output logic line_out,
  output logic line_oe,
  // Byte hand-over and interrupt
  output sws_rx_t rx,
  output logic irq
);
  localparam logic [SWS_CNT_W-1:0] C_RST_MIN = SWS_CNT_W'(RST_MIN_CYC);
  localparam logic [SWS_CNT_W-1:0] C_RST_MAX = SWS_CNT_W'(RST_MAX_CYC);
  localparam logic [SWS_CNT_W-1:0] C_ONE_MAX = SWS_CNT_W'(SWS_ONE_MAX_CYC);
  localparam logic [SWS_CNT_W-1:0] C_WAIT_END = SWS_CNT_W'(SWS_PRES_WAIT_CYC - 1);
  localparam logic [SWS_CNT_W-1:0] C_PRES_END = SWS_CNT_W'(PRES_CYC - 1);
  localparam logic [15:0] TA_MASK = 16'(MEM_SIZE - 1);
  localparam logic [55:0] RN_BODY = {DIE_Y, DIE_X, LOT_WAFER_ID, FAMILY_CODE};
  localparam logic [63:0] REGNUM = {sws_crc8(RN_BODY), RN_BODY};

  // Timing notes:
  // Pulse width counts from the first synchronised low sample,
  // so a pulse of N clock cycles is classed with count N.
  // Line edges reach the counter two cycles late; the wait
  // before presence is counted from the classifying edge.
  // The counter saturates, so a stuck-low line never wraps
  // back into the reset window.
  // Pulses above the reset window drop sync to the init phase;
  // the master then has to send a proper reset.
  // Registration number is fixed at elaboration:
  // family code in byte zero, CRC in byte seven.

  // Elaboration checks on clock rate and parameters
  if (SWS_CLK_MHZ < SWS_MIN_CLK_MHZ) begin : g_bad_clk
    $error("Sampling clock below minimum rate");
  end
  if (RST_MIN_CYC <= SWS_ONE_MAX_CYC || RST_MAX_CYC < RST_MIN_CYC
      || RST_MAX_CYC >= (1 << SWS_CNT_W) - 1 || PRES_CYC < 1) begin : g_bad_time
    $error("Pulse timing parameters out of range");
  end
  if (MEM_SIZE < 32 || MEM_SIZE > 65536 || (MEM_SIZE & (MEM_SIZE - 1)) != 0) begin : g_bad_mem
    $error("Storage size must be a power of two, 32 to 65536");
  end

  sws_state_t st;
  sws_state_t next_st;

  // Next-state logic: line timing, byte assembly, register file
  always_comb begin
    logic rx_bit;
    logic [7:0] new_sh;
    logic [SWS_EV_W-1:0] ev;
    logic [SWS_EV_W-1:0] w1c;
    logic [31:0] rd;
    rx_bit = 1'b0;
    new_sh = 8'h00;
    ev = '0;
    w1c = '0;
    rd = 32'h0000_0000;
    next_st = st;
    next_st.rx.valid = 1'b0;
    // Two-flop synchroniser for the line
    next_st.sync1 = line_in;
    next_st.sync2 = st.sync1;

    // Line state machine: idle, low-pulse measurement, wait before
    // presence, presence drive, and recovery until the line is high.
    case (st.fsm)
      SWS_IDLE: begin
        if (!st.sync2) begin
          next_st.fsm = SWS_LOW;
          next_st.cnt = SWS_CNT_W'(1);
        end
      end
      SWS_LOW: begin
        if (st.sync2) begin
          // Classify the finished low pulse
          next_st.fsm = SWS_IDLE;
          if (st.cnt > C_RST_MAX) begin
            next_st.phase = SWS_PH_INIT; // Overlong: sync lost
          end else if (st.cnt >= C_RST_MIN) begin
            next_st.fsm = SWS_WAIT;
            next_st.cnt = '0;
            next_st.bitcnt = 3'd0;
            next_st.phase = SWS_PH_ROM;
            ev[SWS_EV_RST] = 1'b1;
          end else if (st.phase != SWS_PH_INIT) begin
            // Short pulses before a reset are ignored, so no overdrive reset exists
            rx_bit = (st.cnt <= C_ONE_MAX);
            new_sh = {rx_bit, st.shreg[7:1]};
            next_st.shreg = new_sh;
            next_st.bitcnt = 3'(st.bitcnt + 3'd1);
            if (st.bitcnt == 3'd7) begin
              next_st.rx.valid = 1'b1;
              next_st.rx.phase = st.phase;
              next_st.rx.data = new_sh;
              ev[SWS_EV_BYTE] = 1'b1;
              if (st.phase != SWS_PH_DATA) begin
                next_st.phase = sws_phase_t'(2'(st.phase + 2'd1));
              end
            end
          end
        end else if (st.cnt != '1) begin
          next_st.cnt = SWS_CNT_W'(st.cnt + 1'b1);
        end
      end
      SWS_WAIT: begin
        if (st.cnt == C_WAIT_END) begin
          next_st.fsm = SWS_PRES;
          next_st.cnt = '0;
        end else begin
          next_st.cnt = SWS_CNT_W'(st.cnt + 1'b1);
        end
      end
      SWS_PRES: begin
        if (st.cnt == C_PRES_END) begin
          next_st.fsm = SWS_RECOV;
        end else begin
          next_st.cnt = SWS_CNT_W'(st.cnt + 1'b1);
        end
      end
      SWS_RECOV: begin
        // Own presence still echoes through the synchroniser
        if (st.sync2) begin
          next_st.fsm = SWS_IDLE;
          ev[SWS_EV_PRES] = 1'b1;
        end
      end
      default: begin
        next_st.fsm = SWS_IDLE;
      end
    endcase

    // Disabled front end releases the line and forgets sync
    if (!st.enable) begin
      next_st.fsm = SWS_IDLE;
      next_st.phase = SWS_PH_INIT;
    end

    // Writes land at the edge ending the data phase; read data is
    // built from next-state values so a read right after a write
    // returns the new value.
    // Bus data phase: register writes
    if (st.a_valid && st.a_wr) begin
      case (st.a_addr)
        SWS_A_CTRL: next_st.enable = hwdata[SWS_CTRL_EN];
        SWS_A_TARGET: next_st.ta = hwdata[15:0] & TA_MASK;
        SWS_A_ENDSTAT: begin
          next_st.es_end = hwdata[SWS_ES_END_W-1:0];
          next_st.es_aa = hwdata[SWS_ES_AA];
          next_st.es_pf = hwdata[SWS_ES_PF];
        end
        SWS_A_INT_STAT: w1c = hwdata[SWS_EV_W-1:0];
        SWS_A_INT_MASK: next_st.int_mask = hwdata[SWS_EV_W-1:0];
        default: begin
        end
      endcase
    end
    // Sticky events; a new event wins over its clear
    next_st.int_stat = (st.int_stat & ~w1c) | ev;

    // Bus address phase: capture and prepare read data
    if (hready) begin
      next_st.a_valid = hsel && htrans[1];
      next_st.a_wr = hwrite;
      next_st.a_addr = haddr[7:0];
    end
    case (haddr[7:0])
      SWS_A_CTRL: rd = {31'h0, next_st.enable};
      SWS_A_STATUS: rd = {26'h0, st.sync2, next_st.bitcnt, next_st.phase};
      SWS_A_RXDATA: rd = {22'h0, next_st.rx.phase, next_st.rx.data};
      SWS_A_TARGET: rd = {16'h0, next_st.ta};
      SWS_A_ENDSTAT: rd = {24'h0, next_st.es_pf, 1'b0, next_st.es_aa, next_st.es_end};
      SWS_A_REGNUM_LO: rd = REGNUM[31:0];
      SWS_A_REGNUM_HI: rd = REGNUM[63:32];
      SWS_A_INT_STAT: rd = {29'h0, next_st.int_stat};
      SWS_A_INT_MASK: rd = {29'h0, next_st.int_mask};
      default: rd = 32'h0000_0000;
    endcase
    if (hready && hsel && htrans[1] && !hwrite) begin
      next_st.hrdata = rd;
    end
  end

  // State is one packed record; reset gives the line its idle
  // high level in both synchroniser stages, so no false falling
  // edge is seen right after reset.
  // Enable comes up set, so the line is watched from the start.
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.sync1 <= 1'b1;
      st.sync2 <= 1'b1;
      st.enable <= SWS_CTRL_RST;
      st.ta <= SWS_TA_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.hrdata;
  assign line_out = 1'b0;
  assign line_oe = (st.fsm == SWS_PRES);
  assign rx = st.rx;
  assign irq = |(st.int_stat & st.int_mask);

  // Assertion notes:
  // All checks share the bus clock and are off during reset.
  // Most line checks require the enable bit, since clearing it
  // forces the state machine back to idle at the next edge.
  // The wait count is the package figure itself, the presence count
  // comes through PRES_CYC; recovery waits for the line, not a count.
  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_pres_delay: assert property ($rose(line_oe) |-> $past(st.fsm) == SWS_WAIT && $past(st.cnt) == C_WAIT_END)
    else $error("Presence began without the full wait");
  a_pres_width: assert property ($fell(line_oe) |-> $past(st.cnt) == C_PRES_END)
    else $error("Presence pulse width wrong");
  a_reset_clears: assert property (st.enable && st.fsm == SWS_LOW && st.sync2 && st.cnt >= C_RST_MIN
      && st.cnt <= C_RST_MAX |=> st.bitcnt == 3'd0 && st.phase == SWS_PH_ROM ##1 st.fsm == SWS_WAIT)
    else $error("Reset did not clear bit counter");
  a_one_bit: assert property (st.enable && st.fsm == SWS_LOW && st.sync2 && st.cnt <= C_ONE_MAX
      && st.phase != SWS_PH_INIT |=> st.shreg[7] && st.bitcnt == 3'($past(st.bitcnt) + 3'd1))
    else $error("Short pulse not taken as one");
  a_zero_bit: assert property (st.enable && st.fsm == SWS_LOW && st.sync2 && st.cnt > C_ONE_MAX
      && st.cnt < C_RST_MIN && st.phase != SWS_PH_INIT |=> !st.shreg[7])
    else $error("Long pulse not taken as zero");
  a_init_ignore: assert property (st.phase == SWS_PH_INIT && st.fsm == SWS_LOW && st.sync2
      && st.cnt < C_RST_MIN |=> $stable(st.bitcnt) && !rx.valid)
    else $error("Bit taken before any reset");
  a_byte_done: assert property (rx.valid |-> $past(st.bitcnt) == 3'd7 && st.bitcnt == 3'd0)
    else $error("Byte handed over at wrong bit count");
  a_order_step: assert property (rx.valid && rx.phase == SWS_PH_ROM |-> st.phase == SWS_PH_MEM)
    else $error("Phase did not follow the ROM byte");
  a_es_void: assert property (st.a_valid && !st.a_wr && st.a_addr == SWS_A_ENDSTAT
      |-> !hrdata[SWS_ES_VOID] && hrdata[31:8] == 24'h0)
    else $error("Void status bit read nonzero");
  a_regnum_crc: assert property (hsel && htrans[1] && hready && !hwrite && haddr[7:0] == SWS_A_REGNUM_HI
      |=> hrdata[31:24] == sws_crc8(RN_BODY))
    else $error("Registration number CRC wrong");
  // Falling line starts a measurement
  a_idle_start: assert property (st.enable && st.fsm == SWS_IDLE && !st.sync2
      |=> st.fsm == SWS_LOW && st.cnt == SWS_CNT_W'(1))
    else $error("Low line did not start measurement");
  // Width counter steps once per low cycle
  a_low_count: assert property (st.enable && st.fsm == SWS_LOW && !st.sync2 && st.cnt != '1
      |=> st.cnt == SWS_CNT_W'($past(st.cnt) + 1'b1))
    else $error("Low width counter did not step");
  // Overlong pulse loses sync
  a_overlong_drop: assert property (st.enable && st.fsm == SWS_LOW && st.sync2 && st.cnt > C_RST_MAX
      |=> st.fsm == SWS_IDLE && st.phase == SWS_PH_INIT)
    else $error("Overlong pulse not dropped");
  // Reset pulse raises its event
  a_rst_event: assert property (st.enable && st.fsm == SWS_LOW && st.sync2 && st.cnt >= C_RST_MIN
      && st.cnt <= C_RST_MAX |=> st.int_stat[SWS_EV_RST])
    else $error("Reset event not flagged");
  // Byte hand-over raises its event
  a_byte_event: assert property (rx.valid |-> st.int_stat[SWS_EV_BYTE])
    else $error("Byte event not flagged");
  // Bit state only moves on a classified pulse
  a_bits_frozen: assert property (st.fsm != SWS_LOW |=> $stable(st.bitcnt) && $stable(st.shreg))
    else $error("Bit state moved outside a pulse");
  // Line stays released while waiting
  a_wait_quiet: assert property (st.fsm == SWS_WAIT |-> !line_oe)
    else $error("Line driven during presence wait");
  // Presence drive holds until its count ends
  a_pres_hold: assert property (st.enable && line_oe && st.cnt != C_PRES_END
      |=> line_oe)
    else $error("Presence pulse cut short");
  // Wait before presence runs to its count
  a_wait_count: assert property (st.enable && st.fsm == SWS_WAIT && st.cnt != C_WAIT_END
      |=> st.fsm == SWS_WAIT)
    else $error("Presence wait cut short");
  // Recovery lasts while the line is low
  a_recov_hold: assert property (st.enable && st.fsm == SWS_RECOV && !st.sync2
      |=> st.fsm == SWS_RECOV)
    else $error("Recovery left while line low");
  // Line back high ends recovery with an event
  a_pres_event: assert property (st.enable && st.fsm == SWS_RECOV && st.sync2
      |=> st.int_stat[SWS_EV_PRES] && st.fsm == SWS_IDLE)
    else $error("Presence end not flagged");
  // Memory command byte moves to data
  a_mem_step: assert property (rx.valid && rx.phase == SWS_PH_MEM |-> st.phase == SWS_PH_DATA)
    else $error("Phase did not follow the memory byte");
  // Data bytes keep the data phase
  a_data_stay: assert property (rx.valid && rx.phase == SWS_PH_DATA |-> st.phase == SWS_PH_DATA)
    else $error("Data phase left without reset");
  // Disabled front end returns to idle and init
  a_disable_idle: assert property (!st.enable |=> st.fsm == SWS_IDLE && st.phase == SWS_PH_INIT)
    else $error("Disabled front end still active");
  // Target address stays inside storage
  a_ta_range: assert property ((st.ta & ~TA_MASK) == 16'h0000)
    else $error("Target address beyond storage");
  // Read data stands until the next read
  a_hrdata_hold: assert property (!(hsel && htrans[1] && hready && !hwrite)
      |=> $stable(hrdata))
    else $error("Read data changed without a read");
  // Status bits only clear by a write
  a_stat_sticky: assert property (!(st.a_valid && st.a_wr && st.a_addr == SWS_A_INT_STAT)
      |=> (st.int_stat & $past(st.int_stat)) == $past(st.int_stat))
    else $error("Status bit lost without a clear");
  // Handed-over bytes never carry the init phase
  a_rx_phase_ok: assert property (rx.valid |-> rx.phase != SWS_PH_INIT)
    else $error("Byte handed over before a reset");
  // Older bits shift one place down
  a_bit_shift: assert property (st.enable && st.fsm == SWS_LOW && st.sync2 && st.cnt < C_RST_MIN
      && st.phase != SWS_PH_INIT |=> st.shreg[6:0] == $past(st.shreg[7:1]))
    else $error("Bits not shifted toward bit zero");
  // Handed-over byte lasts one cycle
  a_rx_pulse: assert property (rx.valid |=> !rx.valid)
    else $error("Byte valid longer than one cycle");
  // First bit of a byte counts from zero
  a_first_bit: assert property (st.enable && st.fsm == SWS_LOW && st.sync2 && st.cnt < C_RST_MIN
      && st.phase != SWS_PH_INIT && st.bitcnt == 3'd0 |=> st.bitcnt == 3'd1)
    else $error("First bit not counted");
  // No byte can leave the init phase
  a_init_no_byte: assert property (st.phase == SWS_PH_INIT |=> !rx.valid)
    else $error("Byte taken in init phase");
  // Short pulses in init start nothing
  a_no_fast_reset: assert property (st.enable && st.phase == SWS_PH_INIT && st.fsm == SWS_LOW && st.sync2
      && st.cnt < C_RST_MIN |=> st.fsm == SWS_IDLE && st.phase == SWS_PH_INIT)
    else $error("Short pulse acted on before a reset");
endmodule // sws_frontend
`default_nettype wire

// *** rtl/sws_pkg.sv ***
package sws_pkg;
  // Clock and timing figures in their own units
  localparam int SWS_CLK_NS = 8;
  localparam int SWS_CLK_MHZ = 125;
  localparam int SWS_MIN_CLK_MHZ = 16;
  localparam int SWS_RST_MIN_NS = 460000;
  localparam int SWS_RST_MAX_NS = 600000;
  localparam int SWS_PRES_WAIT_NS = 30000;
  localparam int SWS_PRES_NS = 100000;
  localparam int SWS_ONE_MAX_NS = 15000;

  // Cycle counts: least times round up, longest times round down
  localparam int SWS_RST_MIN_CYC = (SWS_RST_MIN_NS + SWS_CLK_NS - 1) / SWS_CLK_NS;
  localparam int SWS_RST_MAX_CYC = SWS_RST_MAX_NS / SWS_CLK_NS;
  localparam int SWS_PRES_WAIT_CYC = (SWS_PRES_WAIT_NS + SWS_CLK_NS - 1) / SWS_CLK_NS;
  localparam int SWS_PRES_CYC = (SWS_PRES_NS + SWS_CLK_NS - 1) / SWS_CLK_NS;
  localparam int SWS_ONE_MAX_CYC = SWS_ONE_MAX_NS / SWS_CLK_NS;
  localparam int SWS_CNT_W = 17;

  // Register byte offsets
  localparam logic [7:0] SWS_A_CTRL = 8'h00;
  localparam logic [7:0] SWS_A_STATUS = 8'h04;
  localparam logic [7:0] SWS_A_RXDATA = 8'h08;
  localparam logic [7:0] SWS_A_TARGET = 8'h0c;
  localparam logic [7:0] SWS_A_ENDSTAT = 8'h10;
  localparam logic [7:0] SWS_A_REGNUM_LO = 8'h14;
  localparam logic [7:0] SWS_A_REGNUM_HI = 8'h18;
  localparam logic [7:0] SWS_A_INT_STAT = 8'h1c;
  localparam logic [7:0] SWS_A_INT_MASK = 8'h20;

  // Field positions
  localparam int SWS_CTRL_EN = 0;
  localparam int SWS_ES_END_W = 5;
  localparam int SWS_ES_AA = 5;
  localparam int SWS_ES_VOID = 6;
  localparam int SWS_ES_PF = 7;
  localparam int SWS_EV_RST = 0;
  localparam int SWS_EV_BYTE = 1;
  localparam int SWS_EV_PRES = 2;
  localparam int SWS_EV_W = 3;

  // Reset values
  localparam logic SWS_CTRL_RST = 1'b1;
  localparam logic [15:0] SWS_TA_RST = 16'h0000;

  typedef enum logic [2:0] {SWS_IDLE, SWS_LOW, SWS_WAIT, SWS_PRES, SWS_RECOV} sws_fsm_t;
  typedef enum logic [1:0] {SWS_PH_INIT, SWS_PH_ROM, SWS_PH_MEM, SWS_PH_DATA} sws_phase_t;

  // Completed byte handed to command processing
  typedef struct packed {
    logic valid;
    sws_phase_t phase;
    logic [7:0] data;
  } sws_rx_t;

  // Whole state of the front end
  typedef struct packed {
    logic sync1;
    logic sync2;
    sws_fsm_t fsm;
    logic [SWS_CNT_W-1:0] cnt;
    sws_phase_t phase;
    logic [2:0] bitcnt;
    logic [7:0] shreg;
    sws_rx_t rx;
    logic enable;
    logic [15:0] ta;
    logic [SWS_ES_END_W-1:0] es_end;
    logic es_aa;
    logic es_pf;
    logic [SWS_EV_W-1:0] int_stat;
    logic [SWS_EV_W-1:0] int_mask;
    logic a_valid;
    logic a_wr;
    logic [7:0] a_addr;
    logic [31:0] hrdata;
  } sws_state_t;

  // Reflected CRC8 (x^8+x^5+x^4+1), data taken LSB first
  function automatic logic [7:0] sws_crc8(input logic [55:0] d);
    logic [7:0] c;
    logic fb;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      fb = c[0] ^ d[i];
      c = {1'b0, c[7:1]};
      if (fb) begin
        c = c ^ 8'h8c;
      end
    end
    return c;
  endfunction
endpackage

// *** test/sws_master_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Bus master controller on the pulled-up line
module sws_master_model (
  // Clock and line
  input wire logic hclk,
  input wire logic line,
  // Pull-down and presence figures
  output logic drive_low,
  output int pres_len,
  output int pres_gap
);
  int since = 0;
  int low = 0;
  initial begin
    drive_low = 1'b0;
  end
  // Low for w cycles, then free for rec cycles
  task automatic pulse(input int w, input int rec);
    @(posedge hclk);
    drive_low <= 1'b1;
    repeat (w) @(posedge hclk);
    drive_low <= 1'b0;
    repeat (rec) @(posedge hclk);
  endtask
  // Slave pull-down width and quiet time before it
  always @(posedge hclk) begin
    if (drive_low) begin
      since <= 0;
      low <= 0;
    end else if (line === 1'b0) begin
      low <= low + 1;
      if (low == 0) pres_gap <= since;
    end else begin
      since <= since + 1;
      if (low != 0) pres_len <= low;
      low <= 0;
    end
  end
endmodule // sws_master_model
`default_nettype wire

// *** test/single_wire_slave_frontend_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module single_wire_slave_frontend_tb import sws_pkg::*;;
  localparam logic [7:0] FAM = 8'hc3; // Arbitrary value
  localparam logic [31:0] LOT = 32'h89abcdef; // Arbitrary value
  localparam logic [7:0] DX = 8'h3e; // Arbitrary value
  localparam logic [7:0] DY = 8'h71; // Arbitrary value
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, line_out, line_oe, irq, drive_low;
  logic [31:0] hrdata, d;
  sws_rx_t rx;
  sws_rx_t rxq[$];
  int pres_len, pres_gap;
  int bad_count = 0;
  int checked = 0;
  // Pulled-up wire
  wire logic line = !(drive_low | (line_oe & ~line_out));
  sws_frontend #(.RST_MIN_CYC(2000), .RST_MAX_CYC(2600), .PRES_CYC(100), .MEM_SIZE(1024), .FAMILY_CODE(FAM),
    .LOT_WAFER_ID(LOT), .DIE_X(DX), .DIE_Y(DY)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .line_in(line), .line_out(line_out), .line_oe(line_oe), .rx(rx), .irq(irq));
  sws_master_model m (.hclk(hclk), .line(line), .drive_low(drive_low), .pres_len(pres_len), .pres_gap(pres_gap));
  initial begin
    forever #4 hclk = ~hclk;
  end
  // Collect handed-over bytes
  always @(posedge hclk) begin
    if (rx.valid === 1'b1) rxq.push_back(rx);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One AHB-Lite single word transfer
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
    chk({31'h0, hresp}, 32'h0);
    #1;
  endtask
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) m.pulse(b[i] ? 60 : 1950, 20);
  endtask
  function automatic logic [7:0] crc_of(input logic [55:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) c = (c[0] ^ v[i]) ? ({1'b0, c[7:1]} ^ 8'h8c) : {1'b0, c[7:1]};
    return c;
  endfunction
  task automatic t_regs();
    ahb(0, SWS_A_TARGET, 0); chk(d, 32'h0);
    ahb(0, SWS_A_ENDSTAT, 0); chk(d, 32'h0);
    ahb(0, 8'h24, 0); chk(d, 32'h0);
    ahb(1, SWS_A_TARGET, 32'h1ffff);
    ahb(0, SWS_A_TARGET, 0); chk(d, 32'h3ff);
    ahb(1, SWS_A_ENDSTAT, 32'hff);
    ahb(0, SWS_A_ENDSTAT, 0); chk(d, 32'hbf);
    ahb(1, SWS_A_REGNUM_LO, 32'h0);
    ahb(0, SWS_A_REGNUM_LO, 0); chk(d, {LOT[23:0], FAM});
    ahb(0, SWS_A_REGNUM_HI, 0); chk(d, {crc_of({DY, DX, LOT, FAM}), DY, DX, LOT[31:24]});
  endtask
  task automatic t_init_reset();
    m.pulse(60, 20);
    ahb(0, SWS_A_STATUS, 0); chk(d, 32'h20);
    m.pulse(2005, 4000);
    chk(pres_len, 100);
    chk({31'h0, pres_gap >= 3750 && pres_gap <= 3760}, 32'h1);
    ahb(0, SWS_A_STATUS, 0); chk(d, 32'h21);
    ahb(0, SWS_A_INT_STAT, 0); chk(d, 32'h5);
    ahb(1, SWS_A_INT_MASK, 32'h1); chk({31'h0, irq}, 32'h1);
    ahb(1, SWS_A_INT_STAT, 32'h1); chk({31'h0, irq}, 32'h0);
    ahb(0, SWS_A_INT_STAT, 0); chk(d, 32'h4);
    ahb(1, SWS_A_INT_STAT, 32'h4);
    ahb(1, SWS_A_INT_MASK, 32'h2);
  endtask
  task automatic t_bytes();
    logic [7:0] tbl[3] = '{8'ha5, 8'h3c, 8'h81};
    rxq.delete();
    for (int i = 0; i < 3; i++) send_byte(tbl[i]);
    chk(rxq.size(), 3);
    for (int i = 0; i < 3; i++) chk({rxq[i].phase, rxq[i].data}, {i[1:0] + 2'd1, tbl[i]});
    ahb(0, SWS_A_RXDATA, 0); chk(d, 32'h381);
    chk({31'h0, irq}, 32'h1);
    ahb(1, SWS_A_INT_STAT, 32'h2); chk({31'h0, irq}, 32'h0);
  endtask
  task automatic t_partial();
    for (int i = 0; i < 3; i++) m.pulse(60, 20);
    ahb(0, SWS_A_STATUS, 0); chk(d, 32'h2f);
    m.pulse(2595, 4000);
    ahb(0, SWS_A_STATUS, 0); chk(d, 32'h21);
    rxq.delete();
    send_byte(8'h5e);
    chk({rxq[0].phase, rxq[0].data}, {2'd1, 8'h5e});
    m.pulse(2700, 50);
    ahb(0, SWS_A_STATUS, 0); chk(d & 32'h3, 32'h0);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(0, SWS_A_CTRL, 0); chk(d, 32'h1);
    t_regs();
    t_init_reset();
    t_bytes();
    t_partial();
    end_of_test();
  end
  // Watchdog against a hang
  initial begin
    repeat (90000) @(posedge hclk);
    bad_count++;
    end_of_test();
  end
endmodule // single_wire_slave_frontend_tb
`default_nettype wire
